// [design/ebm_top.sv]
`timescale 1ns/100ps

module ebm_buf #(
  parameter  int W  = 18,
  parameter  int D  = 16,
  localparam int PW = $clog2(D)
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         clear_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  typedef struct packed {
    logic [D-1:0][W-1:0] m;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
    logic                rdy;
  } ebm_buf_st_t;

  ebm_buf_st_t s_r;
  ebm_buf_st_t s_nxt;
  logic        push;
  logic        pop;

  always_comb begin
    s_nxt = s_r;
    push  = in_valid_in & s_r.rdy;
    pop   = (s_r.cnt != '0) & out_ready_in;
    if (push) begin
      s_nxt.m[s_r.wp] = in_data_in;
      s_nxt.wp        = s_r.wp + PW'(1);
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + PW'(1);
    end
    s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (clear_in) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
    end
    s_nxt.rdy = s_nxt.cnt != (PW+1)'(D);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '{m: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_out  = s_r.rdy;
  assign out_valid_out = s_r.cnt != '0;
  assign out_data_out  = s_r.m[s_r.rp];
endmodule : ebm_buf

module ebm_top #(
  parameter logic [ebm_pkg::MEM_BITS-1:0] INIT = '0
) (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  input  wire ebm_pkg::ebm_mode_t      mode_in,
  input  wire ebm_pkg::ebm_wbhv_t      wbhv_in,
  input  wire ebm_pkg::ebm_width_t     width_a_in,
  input  wire ebm_pkg::ebm_width_t     width_b_in,
  input  wire logic                    out_reg_en_in,
  input  wire logic                    write_lock_in,
  input  wire logic [ebm_pkg::AW-1:0]  full_threshold_in,
  input  wire logic [ebm_pkg::AW-1:0]  almost_full_threshold_in,
  input  wire logic [ebm_pkg::AW-1:0]  almost_empty_threshold_in,
  input  wire ebm_pkg::ebm_port_t      port_a_in,
  input  wire ebm_pkg::ebm_port_t      port_b_in,
  input  wire logic                    full_input_in,
  input  wire logic                    empty_input_in,
  input  wire logic                    read_strobe_in,
  input  wire logic                    read_pointer_clear_in,
  output logic [ebm_pkg::DW-1:0]       dout_a_out,
  output logic [ebm_pkg::DW-1:0]       dout_b_out,
  output logic                         full_flag_out,
  output logic                         almost_full_flag_out,
  output logic                         empty_flag_out,
  output logic                         almost_empty_flag_out,
  output logic                         write_ready_out
);
  typedef struct packed {
    logic [ebm_pkg::MEM_BITS-1:0]       mem;
    ebm_pkg::ebm_port_t [1:0]           q;
    logic [1:0]                         qv;
    logic                               fq_v;
    logic [ebm_pkg::BW-1:0]             fq_ba;
    logic [1:0][ebm_pkg::DW-1:0]        rd;
    logic [1:0][ebm_pkg::DW-1:0]        dout;
    logic [ebm_pkg::BW-1:0]             wp;
    logic [ebm_pkg::BW-1:0]             rp;
    logic [ebm_pkg::BW-1:0]             fill;
    ebm_pkg::ebm_flags_t                fl;
  } ebm_top_st_t;

  localparam ebm_top_st_t ST_RST = '{
    mem: INIT, q: '0, qv: 2'h0, fq_v: 1'b0, fq_ba: '0, rd: '0, dout: '0,
    wp: '0, rp: '0, fill: '0, fl: ebm_pkg::FLAGS_RST};

  ebm_top_st_t                     s_r;
  ebm_top_st_t                     s_nxt;
  ebm_pkg::ebm_port_t [1:0]        pin;
  ebm_pkg::ebm_width_t [1:0]       wsel;
  logic                            fifo;
  logic                            allow;
  logic                            upd;
  logic                            drain;
  logic                            pop;
  logic                            room;
  logic [4:0]                      ww;
  logic [4:0]                      rw;
  logic [4:0]                      wk;
  logic [ebm_pkg::BW-1:0]          cap;
  logic [ebm_pkg::BW-1:0]          ba;
  logic [ebm_pkg::DW-1:0]          old;
  logic [ebm_pkg::DW-1:0]          res;
  logic                            buf_in_valid;
  logic                            buf_valid;
  logic [ebm_pkg::DW-1:0]          buf_data;

  assign pin  = {port_b_in, port_a_in};
  assign wsel = {width_b_in, width_a_in};
  assign fifo = mode_in == ebm_pkg::M_FIFO;

  function automatic logic [ebm_pkg::DW-1:0] rdword(input logic [ebm_pkg::MEM_BITS-1:0] m,
                                                    input logic [ebm_pkg::BW-1:0] a,
                                                    input logic [4:0] w);
    logic [ebm_pkg::DW-1:0] r;
    r = '0;
    for (int i = 0; i < ebm_pkg::DW; i++) begin
      if (i < int'(w) && int'(a) + i < ebm_pkg::MEM_BITS) begin
        r[i] = m[int'(a) + i];
      end
    end
    return r;
  endfunction : rdword

  function automatic logic [ebm_pkg::MEM_BITS-1:0] wrword(input logic [ebm_pkg::MEM_BITS-1:0] m,
                                                          input logic [ebm_pkg::BW-1:0] a,
                                                          input logic [4:0] w,
                                                          input logic [ebm_pkg::DW-1:0] d,
                                                          input logic [1:0] be);
    logic [ebm_pkg::MEM_BITS-1:0] r;
    logic                         lane;
    r = m;
    for (int i = 0; i < ebm_pkg::DW; i++) begin
      lane = (w == 5'h12) ? be[i / ebm_pkg::LANE_BITS] : 1'b1;
      if (lane && i < int'(w) && int'(a) + i < ebm_pkg::MEM_BITS) begin
        r[int'(a) + i] = d[i];
      end
    end
    return r;
  endfunction : wrword

  function automatic logic reached(input logic [ebm_pkg::BW-1:0] f,
                                   input logic [ebm_pkg::AW-1:0] thr,
                                   input logic [4:0] w);
    logic [17:0] t;
    t = {5'h00, thr} * {13'h0000, w};
    return {4'h0, f} >= t;
  endfunction : reached

  function automatic logic [ebm_pkg::BW-1:0] adv(input logic [ebm_pkg::BW-1:0] p,
                                                 input logic [4:0] w,
                                                 input logic [ebm_pkg::BW-1:0] c);
    logic [ebm_pkg::BW:0] t;
    t = {1'b0, p} + {10'h000, w};
    if (t >= {1'b0, c}) begin
      t = t - {1'b0, c};
    end
    return t[ebm_pkg::BW-1:0];
  endfunction : adv

  function automatic logic fits(input logic [ebm_pkg::BW-1:0] f,
                                input logic [4:0] w,
                                input logic [ebm_pkg::BW-1:0] c);
    logic [ebm_pkg::BW:0] t;
    t = {1'b0, f} + {10'h000, w};
    return t <= {1'b0, c};
  endfunction : fits

  // write side staging, stalls once all BUF_DEPTH entries back up behind a full array fifo
  ebm_buf #(
    .W (ebm_pkg::DW),
    .D (ebm_pkg::BUF_DEPTH)
  ) u_wbuf (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .clear_in      (fifo & port_a_in.rst),
    .in_valid_in   (buf_in_valid),
    .in_data_in    (port_a_in.din),
    .in_ready_out  (write_ready_out),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (drain)
  );

  // staging write taken only with every write select high
  assign buf_in_valid = fifo & port_a_in.ce & port_a_in.cs & port_a_in.we & full_input_in
                        & ~write_lock_in & ~port_a_in.rst;

  always_comb begin
    s_nxt = s_r;
    allow = 1'b0;
    upd   = 1'b0;
    ba    = '0;
    wk    = 5'h01;
    old   = '0;
    res   = '0;
    ww    = ebm_pkg::wbits(width_a_in);
    rw    = ebm_pkg::wbits(width_b_in);
    cap   = ebm_pkg::capacity(width_a_in);
    room  = ~reached(s_r.fill, full_threshold_in, ww) & fits(s_r.fill, ww, cap);
    drain = fifo & buf_valid & room & ~port_a_in.rst;
    pop   = fifo & port_b_in.ce & port_b_in.cs & empty_input_in & read_strobe_in
            & (s_r.fill >= {9'h000, rw}) & ~port_a_in.rst & ~read_pointer_clear_in;

    // input capture per port
    for (int p = 0; p < 2; p++) begin
      unique case (mode_in)
        ebm_pkg::M_SINGLE:      allow = (p == 0);
        ebm_pkg::M_TRUE_DUAL:   allow = 1'b1;
        ebm_pkg::M_PSEUDO_DUAL: allow = (p == 1) | pin[0].we;
        default:                allow = 1'b0;
      endcase
      s_nxt.qv[p] = 1'b0;
      if (pin[p].ce) begin
        s_nxt.q[p]  = pin[p];
        s_nxt.qv[p] = pin[p].cs & allow;
        // writes off for rom use and the pseudo dual read side
        if (write_lock_in || (mode_in == ebm_pkg::M_PSEUDO_DUAL && p == 1)) begin
          s_nxt.q[p].we = 1'b0;
        end
      end
    end

    // array access, port b first so port a wins a collision
    for (int k = 1; k >= 0; k--) begin
      upd = 1'b0;
      res = '0;
      wk  = ebm_pkg::wbits(wsel[k]);
      ba  = ebm_pkg::bitaddr(s_r.q[k].addr, wsel[k]);
      old = rdword(s_r.mem, ba, wk);
      if (s_r.qv[k]) begin
        if (s_r.q[k].we) begin
          s_nxt.mem = wrword(s_nxt.mem, ba, wk, s_r.q[k].din, s_r.q[k].be);
          unique case (wbhv_in)
            ebm_pkg::WB_THROUGH: begin
              upd = 1'b1;
              res = s_r.q[k].din & 18'((18'h00001 << wk) - 18'h00001);
            end
            ebm_pkg::WB_READ_FIRST: begin
              upd = 1'b1;
              res = old;
            end
            default: begin
              upd = 1'b0;
            end
          endcase
        end else begin
          upd = 1'b1;
          res = old;
        end
      end
      // fifo read data on the read side port
      if (k == 1 && s_r.fq_v) begin
        upd = 1'b1;
        res = rdword(s_r.mem, s_r.fq_ba, rw);
      end
      // port reset, then output stage registered or bypassed
      if (pin[k].rst) begin
        s_nxt.rd[k]   = ebm_pkg::DOUT_RST;
        s_nxt.dout[k] = ebm_pkg::DOUT_RST;
      end else begin
        if (upd) begin
          s_nxt.rd[k] = res;
        end
        if (out_reg_en_in) begin
          if (pin[k].output_register_enable) begin
            s_nxt.dout[k] = s_r.rd[k];
          end
        end else if (upd) begin
          s_nxt.dout[k] = res;
        end
      end
    end

    // fifo pointers and fill in bits
    s_nxt.fq_v  = pop;
    s_nxt.fq_ba = s_r.rp;
    if (drain) begin
      s_nxt.mem = wrword(s_nxt.mem, s_r.wp, ww, buf_data, 2'h3);
      s_nxt.wp  = adv(s_r.wp, ww, cap);
    end
    if (pop) begin
      s_nxt.rp = adv(s_r.rp, rw, cap);
    end
    s_nxt.fill = s_r.fill + (drain ? {9'h000, ww} : 14'h0000) - (pop ? {9'h000, rw} : 14'h0000);
    if (fifo && read_pointer_clear_in) begin
      s_nxt.rp   = '0;
      s_nxt.fill = s_nxt.wp;
    end
    // flags follow the next fill
    s_nxt.fl.full   = reached(s_nxt.fill, full_threshold_in, ww) | ~fits(s_nxt.fill, ww, cap);
    s_nxt.fl.afull  = reached(s_nxt.fill, almost_full_threshold_in, ww);
    s_nxt.fl.empty  = s_nxt.fill < {9'h000, rw};
    s_nxt.fl.aempty = ~reached(s_nxt.fill, almost_empty_threshold_in + 13'h0001, rw);
    // global fifo reset, also held outside fifo mode
    if (!fifo || port_a_in.rst) begin
      s_nxt.wp   = '0;
      s_nxt.rp   = '0;
      s_nxt.fill = '0;
      s_nxt.fq_v = 1'b0;
      s_nxt.fl   = ebm_pkg::FLAGS_RST;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign dout_a_out            = s_r.dout[0];
  assign dout_b_out            = s_r.dout[1];
  assign full_flag_out         = s_r.fl.full;
  assign almost_full_flag_out  = s_r.fl.afull;
  assign empty_flag_out        = s_r.fl.empty;
  assign almost_empty_flag_out = s_r.fl.aempty;
endmodule : ebm_top

// [design/ebm_pkg.sv]
package ebm_pkg;
  localparam int DW        = 18;
  localparam int AW        = 13;
  localparam int BW        = 14;
  localparam int MEM_BITS  = 9216;
  localparam int BUF_DEPTH = 16;
  localparam int LANE_BITS = 9;
  localparam logic [BW-1:0] CAP_POW2 = 14'h2000;
  localparam logic [BW-1:0] CAP_NINE = 14'h2400;
  localparam logic [DW-1:0] DOUT_RST = 18'h00000;

  typedef enum logic [4:0] {
    W_X1  = 5'h01,
    W_X2  = 5'h02,
    W_X4  = 5'h04,
    W_X9  = 5'h08,
    W_X18 = 5'h10
  } ebm_width_t;

  typedef enum logic [3:0] {
    M_SINGLE      = 4'h1,
    M_TRUE_DUAL   = 4'h2,
    M_PSEUDO_DUAL = 4'h4,
    M_FIFO        = 4'h8
  } ebm_mode_t;

  typedef enum logic [2:0] {
    WB_NORMAL     = 3'h1,
    WB_THROUGH    = 3'h2,
    WB_READ_FIRST = 3'h4
  } ebm_wbhv_t;

  typedef struct packed {
    logic          ce;
    logic          output_register_enable;
    logic          rst;
    logic [1:0]    be;
    logic          we;
    logic          cs;
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
  } ebm_port_t;

  typedef struct packed {
    logic full;
    logic afull;
    logic empty;
    logic aempty;
  } ebm_flags_t;

  localparam ebm_flags_t FLAGS_RST = '{full: 1'b0, afull: 1'b0, empty: 1'b1, aempty: 1'b1};

  function automatic logic [4:0] wbits(input ebm_width_t w);
    unique case (w)
      W_X1:    return 5'h01;
      W_X2:    return 5'h02;
      W_X4:    return 5'h04;
      W_X9:    return 5'h09;
      W_X18:   return 5'h12;
      default: return 5'h01;
    endcase
  endfunction : wbits

  function automatic logic [AW-1:0] amask(input ebm_width_t w);
    unique case (w)
      W_X1:    return 13'h1fff;
      W_X2:    return 13'h0fff;
      W_X4:    return 13'h07ff;
      W_X9:    return 13'h03ff;
      W_X18:   return 13'h01ff;
      default: return 13'h1fff;
    endcase
  endfunction : amask

  function automatic logic [BW-1:0] bitaddr(input logic [AW-1:0] a, input ebm_width_t w);
    logic [17:0] prod;
    prod = {5'h00, a & amask(w)} * {13'h0000, wbits(w)};
    return prod[BW-1:0];
  endfunction : bitaddr

  function automatic logic [BW-1:0] capacity(input ebm_width_t w);
    return (w == W_X9 || w == W_X18) ? CAP_NINE : CAP_POW2;
  endfunction : capacity
endpackage : ebm_pkg

// [bench/ebm_monitor.sv]
`timescale 1ns/100ps
module ebm_monitor (
  input wire logic                   clk_in,
  input wire logic                   rstn_in,
  input wire ebm_pkg::ebm_mode_t     mode_in,
  input wire ebm_pkg::ebm_wbhv_t     wbhv_in,
  input wire ebm_pkg::ebm_width_t    width_a_in,
  input wire logic                   out_reg_en_in,
  input wire logic                   write_lock_in,
  input wire ebm_pkg::ebm_port_t     port_a_in,
  input wire logic                   full_input_in,
  input wire logic                   read_pointer_clear_in,
  input wire logic [ebm_pkg::DW-1:0] dout_a_out,
  input wire logic                   full_flag_out,
  input wire logic                   almost_full_flag_out,
  input wire logic                   empty_flag_out,
  input wire logic                   almost_empty_flag_out,
  input wire logic                   write_ready_out
);
  logic [8:0] din9;
  logic [4:0] flg;
  logic       wr_a;
  logic       fifo;
  assign din9 = port_a_in.din[8:0];
  assign flg  = {full_flag_out, almost_full_flag_out, empty_flag_out, almost_empty_flag_out, write_ready_out};
  assign fifo = mode_in == ebm_pkg::M_FIFO;
  assign wr_a = port_a_in.ce && port_a_in.cs && port_a_in.we && !port_a_in.rst && !write_lock_in
                && !out_reg_en_in && mode_in == ebm_pkg::M_SINGLE;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  rst_flags_a: assert property (fifo && port_a_in.rst |=> flg == 5'h07)
    else $error("fifo reset left flags wrong");
  empty_aempty_a: assert property (empty_flag_out |-> almost_empty_flag_out)
    else $error("empty without almost empty");
  full_afull_a: assert property (full_flag_out |-> almost_full_flag_out)
    else $error("full without almost full");
  norm_hold_a: assert property (wr_a && wbhv_in == ebm_pkg::WB_NORMAL |-> ##2 $stable(dout_a_out))
    else $error("normal write changed output");
  thru_copy_a: assert property (wr_a && wbhv_in == ebm_pkg::WB_THROUGH && width_a_in == ebm_pkg::W_X9
    |-> ##3 dout_a_out == {9'h000, $past(din9, 3)}) else $error("write data not passed through");
  oreg_hold_a: assert property (out_reg_en_in && !port_a_in.output_register_enable && !port_a_in.rst |=> $stable(dout_a_out))
    else $error("output register moved without enable");
  fullin_gate_a: assert property ((fifo && !full_input_in && !read_pointer_clear_in)[*3] ##0 empty_flag_out
    |=> empty_flag_out) else $error("write taken without write select");
  ready_fall_a: assert property ($fell(write_ready_out) |-> $past(full_flag_out))
    else $error("staging refused while not full");
  cover property (fifo && !write_ready_out);
  cover property (wr_a && wbhv_in == ebm_pkg::WB_READ_FIRST);
  cover property (fifo && port_a_in.rst);
endmodule : ebm_monitor

bind ebm_top ebm_monitor i_mon (.clk_in, .rstn_in, .mode_in, .wbhv_in, .width_a_in, .out_reg_en_in, .write_lock_in,
  .port_a_in, .full_input_in, .read_pointer_clear_in, .dout_a_out, .full_flag_out, .almost_full_flag_out,
  .empty_flag_out, .almost_empty_flag_out, .write_ready_out);

// [bench/ebm_writer.sv]
`timescale 1ns/100ps
module ebm_writer (
  input  wire logic   clk_in,
  input  wire logic   go_in,
  input  wire logic   rdy_in,
  output logic        we_out,
  output logic [17:0] din_out,
  output int          cnt_out
);
  logic took = 1'b0;
  initial begin
    we_out = 1'b0;
    din_out = '0;
    cnt_out = 0;
  end
  // word counted at the edge where ready is seen high
  always @(posedge clk_in) begin
    took <= we_out && rdy_in;
    if (we_out && rdy_in) cnt_out <= cnt_out + 1;
  end
  // request held until taken, random gaps, idle data toggles
  always @(negedge clk_in) begin
    if (took || !we_out) begin
      we_out = go_in && ($urandom % 4 != 0);
      din_out = we_out ? 18'((cnt_out * 7 + 3) % 512) : ~din_out;
    end
  end
endmodule : ebm_writer

// [bench/ebm_tb_top.sv]
`timescale 1ns/100ps
module ebm_tb_top;
  localparam logic [ebm_pkg::MEM_BITS-1:0] INIT_V = {288{32'h5a3c96e1}};
  logic                         clk_in = 1'b0;
  logic                         rstn_in = 1'b0;
  ebm_pkg::ebm_mode_t           mode = ebm_pkg::M_SINGLE;
  ebm_pkg::ebm_wbhv_t           wbhv = ebm_pkg::WB_NORMAL;
  ebm_pkg::ebm_width_t          wa = ebm_pkg::W_X9;
  ebm_pkg::ebm_width_t          wb = ebm_pkg::W_X9;
  ebm_pkg::ebm_port_t           pa = '0;
  ebm_pkg::ebm_port_t           pb = '0;
  ebm_pkg::ebm_port_t           pa_dut;
  logic                         oreg = 1'b0, oce_v = 1'b1, lock = 1'b0, fin = 1'b1, rds = 1'b0, rpc = 1'b0, go = 1'b0;
  logic                         ein = 1'b1;
  logic [1:0]                   be_v = 2'b11;
  logic                         ff, aff, ef, aef, wrdy, w_we;
  logic [17:0]                  da, db, w_din, d, q, old;
  logic [ebm_pkg::MEM_BITS-1:0] mdl = INIT_V;
  int                           w_cnt, a, b, n, dep, rd, err_total = 0, cmp_count = 0;
  ebm_pkg::ebm_width_t          wl [5] = '{ebm_pkg::W_X1, ebm_pkg::W_X2, ebm_pkg::W_X4, ebm_pkg::W_X9, ebm_pkg::W_X18};
  int                           wn [5] = '{1, 2, 4, 9, 18};

  always #5 clk_in = ~clk_in;
  always_comb begin
    pa_dut = pa;
    pa_dut.we = pa.we | w_we;
    if (w_we) pa_dut.din = w_din;
  end

  ebm_top #(.INIT(INIT_V)) i_dut (.clk_in, .rstn_in, .mode_in(mode), .wbhv_in(wbhv), .width_a_in(wa), .width_b_in(wb),
    .out_reg_en_in(oreg), .write_lock_in(lock), .full_threshold_in(13'h0008), .almost_full_threshold_in(13'h0004),
    .almost_empty_threshold_in(13'h0002), .port_a_in(pa_dut), .port_b_in(pb), .full_input_in(fin),
    .empty_input_in(ein), .read_strobe_in(rds), .read_pointer_clear_in(rpc), .dout_a_out(da), .dout_b_out(db),
    .full_flag_out(ff), .almost_full_flag_out(aff), .empty_flag_out(ef), .almost_empty_flag_out(aef),
    .write_ready_out(wrdy));
  ebm_writer i_wr (.clk_in, .go_in(go), .rdy_in(wrdy), .we_out(w_we), .din_out(w_din), .cnt_out(w_cnt));

  task automatic chk(string nm, logic [17:0] seen, logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [17:0] rdx(int ad, int nn);
    logic [17:0] r;
    r = '0;
    for (int i = 0; i < nn; i++) r[i] = mdl[ad*nn+i];
    return r;
  endfunction : rdx
  task automatic setup(ebm_pkg::ebm_mode_t m, ebm_pkg::ebm_width_t x, ebm_pkg::ebm_width_t y);
    rstn_in = 1'b0;
    mode = m;
    wa = x;
    wb = y;
    mdl = INIT_V;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
  endtask : setup
  // one access, result taken when the output has settled
  task automatic op(bit bp, bit w, int ad, logic [17:0] dd, int nn, output logic [17:0] qq);
    ebm_pkg::ebm_port_t p;
    p = '{ce: 1'b1, output_register_enable: oce_v, rst: 1'b0, be: be_v, we: w, cs: 1'b1, addr: 13'(ad), din: dd};
    for (int i = 0; i < nn; i++) begin
      if (w && !lock && (nn != 18 || be_v[i / 9])) mdl[ad*nn+i] = dd[i];
    end
    if (bp) pb = p;
    else pa = p;
    @(negedge clk_in);
    pa.ce = 1'b0;
    pb.ce = 1'b0;
    repeat (oreg ? 3 : 2) @(negedge clk_in);
    qq = bp ? db : da;
  endtask : op
  task automatic rd1(output logic [17:0] qq);
    rds = 1'b1;
    @(negedge clk_in);
    rds = 1'b0;
    repeat (2) @(negedge clk_in);
    qq = db;
  endtask : rd1
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    #300000;
    err_total++;
    stop_test;
  end

  initial begin
    void'($urandom(61988));
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    chk("rst_flags", {ff, aff, ef, aef, wrdy}, 18'h07);
    lock = 1'b1;
    for (int j = 0; j < 4; j++) begin
      a = $urandom % 1024;
      op(0, 1, a, 18'($urandom), 9, q);
      chk("rom", q, rdx(a, 9));
    end
    lock = 1'b0;
    $display("test rom done");
    for (int k = 0; k < 5; k++) begin
      n = wn[k == 4 ? 4 : 3 - k];
      setup(k == 4 ? ebm_pkg::M_PSEUDO_DUAL : ebm_pkg::M_TRUE_DUAL, wl[k], wl[k == 4 ? 4 : 3 - k]);
      dep = (k == 4 ? 9216 : 8192) / wn[k];
      for (int j = 0; j < 6; j++) begin
        be_v = (k == 4 && j > 0) ? 2'(1 + j % 2) : 2'b11;
        a = (j == 0) ? dep - 1 : $urandom % dep;
        op(0, 1, a, 18'($urandom), wn[k], q);
        b = a * wn[k] / n;
        op(1, 0, b, '0, n, q);
        chk("width", q, rdx(b, n));
      end
    end
    be_v = 2'b11;
    $display("test widths done");
    setup(ebm_pkg::M_SINGLE, ebm_pkg::W_X9, ebm_pkg::W_X9);
    for (int k = 0; k < 3; k++) begin
      wbhv = ebm_pkg::ebm_wbhv_t'(3'h1 << k);
      a = $urandom % 1024;
      b = (a + 1) % 1024;
      op(0, 0, b, '0, 9, q);
      old = rdx(a, 9);
      d = 18'($urandom);
      op(0, 1, a, d, 9, q);
      chk("wbhv", q, k == 1 ? {9'h000, d[8:0]} : k == 2 ? old : rdx(b, 9));
      op(0, 0, a, '0, 9, q);
      chk("readback", q, rdx(a, 9));
    end
    wbhv = ebm_pkg::WB_NORMAL;
    oreg = 1'b1;
    op(0, 0, 5, '0, 9, q);
    chk("oreg", q, rdx(5, 9));
    oce_v = 1'b0;
    op(0, 0, 6, '0, 9, d);
    chk("oreg_hold", d, rdx(5, 9));
    oreg = 1'b0;
    oce_v = 1'b1;
    $display("test ram done");
    setup(ebm_pkg::M_FIFO, ebm_pkg::W_X9, ebm_pkg::W_X9);
    pa = '{ce: 1'b1, output_register_enable: 1'b1, rst: 1'b0, be: 2'b11, we: 1'b1, cs: 1'b1, addr: '0, din: '0};
    pb = pa;
    pb.we = 1'b0;
    fin = 1'b0;
    repeat (6) @(negedge clk_in);
    chk("gate", ef, 1);
    pa.we = 1'b0;
    fin = 1'b1;
    go = 1'b1;
    repeat (150) @(negedge clk_in);
    chk("fill", {ff, aff, ef, wrdy}, 18'hc);
    go = 1'b0;
    ein = 1'b0;
    rd1(q);
    chk("ein_gate", q, 18'h0);
    ein = 1'b1;
    for (rd = 0; rd < w_cnt; rd++) begin
      rd1(q);
      chk("order", q, 18'((rd * 7 + 3) % 512));
    end
    repeat (3) @(negedge clk_in);
    chk("drained", {ef, aef}, 18'h3);
    rpc = 1'b1;
    @(negedge clk_in);
    rpc = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("clr_flag", ef, 0);
    rd1(q);
    chk("reread", q, 18'h3);
    pa.rst = 1'b1;
    @(negedge clk_in);
    pa.rst = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("grst", {ff, aff, ef, aef, wrdy}, 18'h07);
    $display("test fifo done");
    stop_test;
  end
endmodule : ebm_tb_top
